//--- inc/pi_reg_consts.svh
// Constants for the process regulator: scales, codes, widths and timing counts.
// Assumes a 25 MHz system clock and a fixed 1 ms regulator sample period.
`ifndef PI_REG_CONSTS_SVH
`define PI_REG_CONSTS_SVH
`define CLK_PERIOD_NS 40
`define SAMPLE_PERIOD_NS 1000000
`define SAMPLE_CYCLES (`SAMPLE_PERIOD_NS / `CLK_PERIOD_NS)
`define TI_UNIT_NS 100000000
`define LAG_UNIT_NS 10000000
`define TI_SAMPLES (`TI_UNIT_NS / `SAMPLE_PERIOD_NS)
`define LAG_SAMPLES (`LAG_UNIT_NS / `SAMPLE_PERIOD_NS)
`define LOSS_SAMPLES (`TI_UNIT_NS / `SAMPLE_PERIOD_NS)
`define SIG_W 18
`define SIG_MAX 20000
`define WIDE_W 48
`define FRAC_W 16
`define DIV_NW 32
`define DIV_DW 20
`define LOSS_CW 15
`define KP_SCALE 100
`define OG_SCALE 10
`define PCT10_SCALE 10
`define PCT1_SCALE 100
`define FN_FEEDBACK 5'h0b
`define FN_DIFF 5'h10
`define COMM_SP_BIT 1
`endif

//--- inc/pi_reg_pkg.sv
// Types shared by the process regulator files.
// Assumes pi_reg_consts.svh is on the include path.
`include "pi_reg_consts.svh"
package pi_reg_pkg;
  typedef logic signed [`WIDE_W-1:0] wide_t;
  typedef enum logic [1:0] {MODE_OFF = 2'h0, MODE_DRIVE = 2'h1, MODE_TRIM = 2'h3} mode_t;
  typedef enum logic [1:0] {SRC_PRESET = 2'h0, SRC_ANALOG = 2'h1, SRC_SERIAL = 2'h2,
                            SRC_OPTION = 2'h3} source_t;
  typedef enum logic [1:0] {LOSS_OFF = 2'h0, LOSS_ALARM = 2'h1, LOSS_FAULT = 2'h2} loss_sel_t;
  typedef enum logic [4:0] {ST_IDLE = 5'h01, ST_INTEG = 5'h02, ST_FSTART = 5'h04,
                            ST_FILT = 5'h08, ST_OUTP = 5'h10} reg_state_t;
endpackage

//--- rtl/div_serial.sv
// Unsigned restoring divider, one quotient bit per enabled clock.
// Assumes the caller never starts it with a zero divisor.
`timescale 1ns/1ps
module div_serial #(
  parameter int NW = 32,
  parameter int DW = 16
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic [NW-1:0] num_in,
  input wire logic [DW-1:0] den_in,
  output logic done_out,
  output logic [NW-1:0] quo_out
);
  localparam int CW = $clog2(NW + 1);
  logic [DW-1:0] rem;
  logic [DW-1:0] den;
  logic [CW-1:0] cnt;
  logic [DW:0] shifted;

  assign shifted = {rem, quo_out[NW-1]};

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rem <= '0;
      den <= '0;
      cnt <= '0;
      quo_out <= '0;
      done_out <= 1'b0;
    end else if (ce_in) begin
      done_out <= 1'b0;
      if (start_in) begin
        quo_out <= num_in;
        den <= den_in;
        rem <= '0;
        cnt <= CW'(NW);
      end else if (cnt != '0) begin
        if (shifted >= {1'b0, den}) begin
          rem <= DW'(shifted - {1'b0, den});
          quo_out <= {quo_out[NW-2:0], 1'b1};
        end else begin
          rem <= shifted[DW-1:0];
          quo_out <= {quo_out[NW-2:0], 1'b0};
        end
        cnt <= cnt - 1'b1;
        done_out <= (cnt == CW'(1));
      end
    end
  end
endmodule

//--- rtl/loss_timer.sv
// Feedback loss qualifier: counts sample ticks while feedback sits below a level.
// Assumes level and feedback share one signed scale and tick is a one-cycle pulse.
`timescale 1ns/1ps
`include "pi_reg_consts.svh"
module loss_timer #(
  parameter int CW = `LOSS_CW
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic tick_in,
  input wire logic enable_in,
  input wire logic signed [`SIG_W-1:0] level_in,
  input wire logic signed [`SIG_W-1:0] feedback_in,
  input wire logic [CW-1:0] samples_in,
  output logic lost_out
);
  logic [CW-1:0] cnt;
  logic below;

  assign below = feedback_in < level_in;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cnt <= '0;
      lost_out <= 1'b0;
    end else if (ce_in) begin
      if (!enable_in || !below) begin
        cnt <= '0;
        lost_out <= 1'b0;
      end else if (tick_in) begin
        if (cnt >= samples_in) begin
          lost_out <= 1'b1;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  property p_clear_above;
    (ce_in && !below) |=> !lost_out;
  endproperty
  a_clear_above: assert property (p_clear_above) else $error("loss held with feedback above level");

  property p_full_time;
    $rose(lost_out) |-> ($past(cnt) >= $past(samples_in)) && $past(below) && $past(tick_in);
  endproperty
  a_full_time: assert property (p_full_time) else $error("loss declared before its time");

  c_lost: cover property (ce_in && $rose(lost_out));
endmodule

//--- rtl/pi_process_regulator.sv
// Process regulator: setpoint selection, PI with limits, lag filter and loss detection.
// Assumes settings come from logic on sys_clk_in; analog inputs arrive from pins.
`timescale 1ns/1ps
`include "pi_reg_consts.svh"
module pi_process_regulator #(
  parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic signed [`SIG_W-1:0] first_analog_input_in,
  input wire logic signed [`SIG_W-1:0] second_analog_input_in,
  input wire logic [4:0] second_input_function_in,
  input wire logic [1:0] speed_command_source_in,
  input wire logic signed [`SIG_W-1:0] first_preset_speed_in,
  input wire logic signed [`SIG_W-1:0] serial_speed_in,
  input wire logic signed [`SIG_W-1:0] option_board_speed_in,
  input wire logic signed [`SIG_W-1:0] comm_setpoint_06_in,
  input wire logic [15:0] comm_flags_0f_in,
  input wire logic stored_setpoint_enable_in,
  input wire logic [13:0] stored_setpoint_value_in,
  input wire logic [1:0] regulator_mode_select_in,
  input wire logic [11:0] proportional_gain_in,
  input wire logic [11:0] integral_time_in,
  input wire logic [9:0] integral_clamp_in,
  input wire logic [9:0] output_clamp_in,
  input wire logic signed [10:0] offset_adjust_in,
  input wire logic [9:0] lag_time_constant_in,
  input wire logic output_polarity_in,
  input wire logic [7:0] output_gain_in,
  input wire logic reverse_allow_in,
  input wire logic [1:0] loss_detect_select_in,
  input wire logic [6:0] loss_detect_level_in,
  input wire logic [7:0] loss_detect_time_in,
  input wire logic fault_reset_in,
  output logic signed [`SIG_W-1:0] speed_command_out,
  output logic signed [`SIG_W-1:0] regulator_output_out,
  output logic regulator_active_out,
  output logic feedback_loss_alarm_out,
  output logic fault_relay_out,
  output logic drive_enable_out
);
  localparam int TW = $clog2(SAMPLE_CYCLES + 1);
  localparam pi_reg_pkg::wide_t SMAX = pi_reg_pkg::wide_t'(`SIG_MAX);

  function automatic pi_reg_pkg::wide_t clampw(input pi_reg_pkg::wide_t v,
                                               input pi_reg_pkg::wide_t lim);
    if (v > lim) begin
      return lim;
    end else if (v < -lim) begin
      return -lim;
    end
    return v;
  endfunction

  function automatic pi_reg_pkg::wide_t absw(input pi_reg_pkg::wide_t v);
    return (v < 0) ? -v : v;
  endfunction

  pi_reg_pkg::reg_state_t state;
  logic signed [`SIG_W-1:0] in1_meta, in1_sync, in2_meta, in2_sync;
  logic [TW-1:0] tick_cnt;
  logic tick;
  logic fb_mode, diff_mode, active, lost, fault;
  logic err_neg, dif_neg;
  logic signed [`SIG_W-1:0] p_r;
  pi_reg_pkg::wide_t integ_acc, filt_acc, quo_w;
  pi_reg_pkg::wide_t spd_cmd, setpoint, feedback, err, p_term, i_term;
  pi_reg_pkg::wide_t ilim, olim, offs, x_val, y_val, g_val, s_val;
  logic div_start, div_done;
  logic [`DIV_NW-1:0] div_num, div_quo;
  logic [`DIV_DW-1:0] div_den;
  logic signed [`SIG_W-1:0] loss_level;
  logic [`LOSS_CW-1:0] loss_samples;

  // Multi-bit samples are synchronised per bit; a converter word that changes
  // mid-capture can show one mixed sample; only a nonzero lag filter absorbs it, and not on the pass-through speed path.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      in1_meta <= '0;
      in1_sync <= '0;
      in2_meta <= '0;
      in2_sync <= '0;
    end else if (ce_in) begin
      in1_meta <= first_analog_input_in;
      in1_sync <= in1_meta;
      in2_meta <= second_analog_input_in;
      in2_sync <= in2_meta;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (ce_in) begin
      tick <= (tick_cnt == TW'(SAMPLE_CYCLES - 1));
      tick_cnt <= (tick_cnt == TW'(SAMPLE_CYCLES - 1)) ? '0 : tick_cnt + 1'b1;
    end
  end

  assign fb_mode = second_input_function_in == `FN_FEEDBACK;
  assign diff_mode = second_input_function_in == `FN_DIFF;
  assign active = (regulator_mode_select_in == pi_reg_pkg::MODE_DRIVE ||
                   regulator_mode_select_in == pi_reg_pkg::MODE_TRIM) &&
                  (fb_mode || diff_mode);
  assign ilim = pi_reg_pkg::wide_t'(integral_clamp_in) * `PCT10_SCALE;
  assign olim = pi_reg_pkg::wide_t'(output_clamp_in) * `PCT10_SCALE;
  assign offs = pi_reg_pkg::wide_t'(offset_adjust_in) * `PCT10_SCALE;
  assign quo_w = pi_reg_pkg::wide_t'(div_quo);

  always_comb begin
    case (speed_command_source_in)
      pi_reg_pkg::SRC_PRESET: spd_cmd = pi_reg_pkg::wide_t'(first_preset_speed_in);
      pi_reg_pkg::SRC_ANALOG: spd_cmd = pi_reg_pkg::wide_t'(in1_sync);
      pi_reg_pkg::SRC_SERIAL: spd_cmd = pi_reg_pkg::wide_t'(serial_speed_in);
      default: spd_cmd = pi_reg_pkg::wide_t'(option_board_speed_in);
    endcase
  end

  always_comb begin
    if (diff_mode) begin
      setpoint = offs;
      feedback = clampw(pi_reg_pkg::wide_t'(in1_sync) - pi_reg_pkg::wide_t'(in2_sync), SMAX);
    end else begin
      feedback = pi_reg_pkg::wide_t'(in2_sync);
      if (stored_setpoint_enable_in) begin
        setpoint = pi_reg_pkg::wide_t'(stored_setpoint_value_in);
      end else if (comm_flags_0f_in[`COMM_SP_BIT]) begin
        setpoint = pi_reg_pkg::wide_t'(comm_setpoint_06_in);
      end else begin
        setpoint = spd_cmd;
      end
    end
  end

  // Every sum and product is formed wide and saturated back into range.
  always_comb begin
    err = clampw(output_polarity_in ? feedback - setpoint : setpoint - feedback,
                 SMAX);
    p_term = clampw(err * pi_reg_pkg::wide_t'(proportional_gain_in) / `KP_SCALE,
                    SMAX);
    i_term = clampw(integ_acc >>> `FRAC_W, ilim);
    x_val = clampw(pi_reg_pkg::wide_t'(p_r) + i_term, SMAX);
    y_val = filt_acc >>> `FRAC_W;
    g_val = clampw(y_val * pi_reg_pkg::wide_t'(output_gain_in) / `OG_SCALE, SMAX);
    if (!diff_mode) begin
      g_val = clampw(g_val + offs, SMAX);
    end
    g_val = clampw(g_val, olim);
    if (!active) begin
      s_val = spd_cmd;
    end else if (regulator_mode_select_in == pi_reg_pkg::MODE_TRIM) begin
      s_val = clampw(spd_cmd + g_val, SMAX);
    end else begin
      s_val = g_val;
    end
    if (active && !reverse_allow_in && s_val < 0) begin
      s_val = '0;
    end
  end

  // One divider serves the integral step and then the filter step of a sample.
  always_comb begin
    div_start = 1'b0;
    div_num = '0;
    div_den = '0;
    if (state == pi_reg_pkg::ST_IDLE && tick && active && integral_time_in != '0) begin
      div_start = 1'b1;
      div_num = `DIV_NW'(absw(err) << `FRAC_W);
      div_den = `DIV_DW'(integral_time_in * `TI_SAMPLES);
    end else if (state == pi_reg_pkg::ST_FSTART && lag_time_constant_in != '0) begin
      div_start = 1'b1;
      div_num = `DIV_NW'(absw(x_val - y_val) << `FRAC_W);
      div_den = `DIV_DW'(lag_time_constant_in * `LAG_SAMPLES);
    end
  end

  div_serial #(.NW(`DIV_NW), .DW(`DIV_DW)) u_div (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .start_in(div_start),
    .num_in(div_num),
    .den_in(div_den),
    .done_out(div_done),
    .quo_out(div_quo)
  );

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state <= pi_reg_pkg::ST_IDLE;
      p_r <= '0;
      err_neg <= 1'b0;
      dif_neg <= 1'b0;
    end else if (ce_in) begin
      case (state)
        pi_reg_pkg::ST_IDLE: begin
          if (tick) begin
            p_r <= p_term[`SIG_W-1:0];
            err_neg <= err < 0;
            if (!active) begin
              state <= pi_reg_pkg::ST_OUTP;
            end else if (integral_time_in != '0) begin
              state <= pi_reg_pkg::ST_INTEG;
            end else begin
              state <= pi_reg_pkg::ST_FSTART;
            end
          end
        end
        pi_reg_pkg::ST_INTEG: begin
          if (div_done) begin
            state <= pi_reg_pkg::ST_FSTART;
          end
        end
        pi_reg_pkg::ST_FSTART: begin
          dif_neg <= x_val < y_val;
          state <= (lag_time_constant_in != '0) ? pi_reg_pkg::ST_FILT : pi_reg_pkg::ST_OUTP;
        end
        pi_reg_pkg::ST_FILT: begin
          if (div_done) begin
            state <= pi_reg_pkg::ST_OUTP;
          end
        end
        pi_reg_pkg::ST_OUTP: state <= pi_reg_pkg::ST_IDLE;
        default: state <= pi_reg_pkg::ST_IDLE;
      endcase
    end
  end

  // The accumulator itself is clamped so it cannot wind up past the limit.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      integ_acc <= '0;
    end else if (ce_in) begin
      if (!active || integral_time_in == '0) begin
        integ_acc <= '0;
      end else if (state == pi_reg_pkg::ST_INTEG && div_done) begin
        integ_acc <= clampw(err_neg ? integ_acc - quo_w : integ_acc + quo_w,
                            ilim <<< `FRAC_W);
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      filt_acc <= '0;
    end else if (ce_in) begin
      if (!active) begin
        filt_acc <= '0;
      end else if (state == pi_reg_pkg::ST_FSTART && lag_time_constant_in == '0) begin
        filt_acc <= x_val <<< `FRAC_W;
      end else if (state == pi_reg_pkg::ST_FILT && div_done) begin
        filt_acc <= dif_neg ? filt_acc - quo_w : filt_acc + quo_w;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      speed_command_out <= '0;
      regulator_output_out <= '0;
      regulator_active_out <= 1'b0;
    end else if (ce_in) begin
      regulator_active_out <= active;
      if (state == pi_reg_pkg::ST_OUTP) begin
        speed_command_out <= s_val[`SIG_W-1:0];
        regulator_output_out <= active ? g_val[`SIG_W-1:0] : '0;
      end
    end
  end

  assign loss_level = `SIG_W'(loss_detect_level_in * `PCT1_SCALE);
  assign loss_samples = `LOSS_CW'(loss_detect_time_in * `LOSS_SAMPLES);

  loss_timer #(.CW(`LOSS_CW)) u_loss (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .tick_in(tick),
    .enable_in(active && loss_detect_select_in != pi_reg_pkg::LOSS_OFF),
    .level_in(loss_level),
    .feedback_in(feedback[`SIG_W-1:0]),
    .samples_in(loss_samples),
    .lost_out(lost)
  );

  // A fault latches until reset; a loss arriving with the reset keeps it set.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      fault <= 1'b0;
      feedback_loss_alarm_out <= 1'b0;
    end else if (ce_in) begin
      feedback_loss_alarm_out <= lost && loss_detect_select_in == pi_reg_pkg::LOSS_ALARM;
      if (lost && loss_detect_select_in == pi_reg_pkg::LOSS_FAULT) begin
        fault <= 1'b1;
      end else if (fault_reset_in) begin
        fault <= 1'b0;
      end
    end
  end

  assign fault_relay_out = fault;
  assign drive_enable_out = !fault;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  property p_polarity;
    (setpoint > feedback) |-> (output_polarity_in ? err < 0 : err > 0);
  endproperty
  a_polarity: assert property (p_polarity) else $error("error sign ignores polarity");

  property p_integ_off;
    (ce_in && !active) |=> integ_acc == 0;
  endproperty
  a_integ_off: assert property (p_integ_off) else $error("integral kept while disabled");

  property p_ti_zero;
    (ce_in && integral_time_in == '0) |=> integ_acc == 0;
  endproperty
  a_ti_zero: assert property (p_ti_zero) else $error("integration with zero time");

  property p_iclamp;
    (ce_in && active && div_done && state == pi_reg_pkg::ST_INTEG) ##1 $stable(ilim)
      |-> absw(integ_acc) <= (ilim <<< `FRAC_W);
  endproperty
  a_iclamp: assert property (p_iclamp) else $error("integral above its limit");

  property p_out_clamp;
    (ce_in && active && state == pi_reg_pkg::ST_OUTP) |=>
      absw(pi_reg_pkg::wide_t'(regulator_output_out)) <= $past(olim);
  endproperty
  a_out_clamp: assert property (p_out_clamp) else $error("output above its limit");

  property p_no_reverse;
    (ce_in && active && !reverse_allow_in && state == pi_reg_pkg::ST_OUTP) |=>
      speed_command_out >= 0;
  endproperty
  a_no_reverse: assert property (p_no_reverse) else $error("reverse speed not allowed");

  property p_pass;
    (ce_in && !active && state == pi_reg_pkg::ST_OUTP) |=>
      pi_reg_pkg::wide_t'(speed_command_out) == $past(spd_cmd);
  endproperty
  a_pass: assert property (p_pass) else $error("speed altered while disabled");

  property p_fault;
    (ce_in && lost && loss_detect_select_in == pi_reg_pkg::LOSS_FAULT) |=>
      fault_relay_out && !drive_enable_out;
  endproperty
  a_fault: assert property (p_fault) else $error("loss fault did not trip");

  property p_alarm_only;
    (ce_in && !fault && !(lost && loss_detect_select_in == pi_reg_pkg::LOSS_FAULT)) |=>
      !fault_relay_out && drive_enable_out;
  endproperty
  a_alarm_only: assert property (p_alarm_only) else $error("fault without fault selection");

  c_trim: cover property (ce_in && active && state == pi_reg_pkg::ST_OUTP &&
                          regulator_mode_select_in == pi_reg_pkg::MODE_TRIM);
  c_fault: cover property (ce_in && $rose(fault));
  c_ilimit: cover property (active && absw(integ_acc) == (ilim <<< `FRAC_W) && ilim != 0);
endmodule

//--- tb/process_transmitter.sv
// Model of the process transmitter and of the reference signal on the first analog input.
// Assumes the bench sets the levels at the falling clock edge.
`timescale 1ns/1ps
`include "pi_reg_consts.svh"
module process_transmitter (
  input wire logic sys_clk_in,
  input wire logic broken_in,
  input wire logic signed [`SIG_W-1:0] level_in,
  input wire logic signed [`SIG_W-1:0] reference_in,
  output logic signed [`SIG_W-1:0] first_analog_input_out,
  output logic signed [`SIG_W-1:0] second_analog_input_out
);
  // A broken loop reads near zero with a ripple, never a clean held value.
  logic ripple = 1'b0;
  always @(posedge sys_clk_in) begin
    ripple <= ~ripple;
  end
  assign first_analog_input_out = reference_in;
  assign second_analog_input_out = broken_in ? {17'h00000, ripple} : level_in;
endmodule

//--- tb/tb_pi_process_regulator.sv
// Self-checking bench for the process regulator with a shortened sample period.
// Assumes the transmitter model drives both analog inputs.
`timescale 1ns/1ps
`include "pi_reg_consts.svh"
module tb_pi_process_regulator;
  localparam int SC = 100;
  logic sys_clk = 1'b0, rst = 1'b1, broken = 1'b0, sp_en = 1'b1, pol = 1'b0, rev = 1'b0;
  logic freset = 1'b0, ce = 1'b1, active, alarm, fault, drv_en;
  logic signed [`SIG_W-1:0] fb = 18'h00bb8, refl = 18'h00fa0, preset = 18'h00064;
  logic signed [`SIG_W-1:0] serial = 18'h000c8, opt = 18'h0012c, comm = 18'h01770;
  logic signed [`SIG_W-1:0] ain1, ain2, speed, regout;
  logic [4:0] func = 5'h0b;
  logic [1:0] src = 2'h0, mode = 2'h0, lsel = 2'h0;
  logic [15:0] flags = 16'h0000;
  logic [13:0] sp_val = 14'h1388;
  logic [11:0] kp = 12'h064, ti = 12'h000;
  logic [9:0] iclamp = 10'h3e8, oclamp = 10'h3e8, lag = 10'h000;
  logic signed [10:0] offset = 11'h000;
  logic [7:0] gain = 8'h0a, ltime = 8'h01;
  logic [6:0] llvl = 7'h0a;
  int num_errors = 0, compares = 0, cycles = 0;
  logic signed [`SIG_W-1:0] src_exp [4];

  always #20 sys_clk = ~sys_clk;

  process_transmitter i_xmtr (.sys_clk_in(sys_clk), .broken_in(broken), .level_in(fb),
    .reference_in(refl), .first_analog_input_out(ain1), .second_analog_input_out(ain2));

  pi_process_regulator #(.SAMPLE_CYCLES(SC)) i_dut (.sys_clk_in(sys_clk), .rst_in(rst),
    .ce_in(ce), .first_analog_input_in(ain1), .second_analog_input_in(ain2),
    .second_input_function_in(func), .speed_command_source_in(src),
    .first_preset_speed_in(preset), .serial_speed_in(serial), .option_board_speed_in(opt),
    .comm_setpoint_06_in(comm), .comm_flags_0f_in(flags), .stored_setpoint_enable_in(sp_en),
    .stored_setpoint_value_in(sp_val), .regulator_mode_select_in(mode),
    .proportional_gain_in(kp), .integral_time_in(ti), .integral_clamp_in(iclamp),
    .output_clamp_in(oclamp), .offset_adjust_in(offset), .lag_time_constant_in(lag),
    .output_polarity_in(pol), .output_gain_in(gain), .reverse_allow_in(rev),
    .loss_detect_select_in(lsel), .loss_detect_level_in(llvl),
    .loss_detect_time_in(ltime), .fault_reset_in(freset), .speed_command_out(speed),
    .regulator_output_out(regout), .regulator_active_out(active),
    .feedback_loss_alarm_out(alarm), .fault_relay_out(fault), .drive_enable_out(drv_en));

  task automatic chk(input logic [`SIG_W-1:0] got, input logic [`SIG_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waiting whole samples keeps every check clear of the output update edge.
  task automatic samples(input int n);
    repeat (n * SC) @(negedge sys_clk);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // The loss test dominates the run at roughly 250 samples.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      report_and_stop();
    end
  end

  initial begin
    src_exp = '{preset, refl, serial, opt};
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    chk(speed, 18'h00000);
    chk(drv_en, 1'b1);
    for (int s = 0; s < 4; s++) begin
      src = s[1:0];
      samples(2);
      chk(speed, src_exp[s]);
      chk(regout, 18'h00000);
      chk(active, 1'b0);
    end
    // With the clock enable low the source change must not reach the output.
    ce = 1'b0;
    src = 2'h0;
    samples(2);
    chk(speed, opt);
    ce = 1'b1;
    mode = 2'h1;
    samples(2);
    chk(active, 1'b1);
    chk(regout, 18'h007d0);
    chk(speed, 18'h007d0);
    pol = 1'b1;
    samples(2);
    chk(regout, 18'h3f830);
    chk(speed, 18'h00000);
    rev = 1'b1;
    samples(2);
    chk(speed, 18'h3f830);
    pol = 1'b0;
    rev = 1'b0;
    gain = 8'h14;
    samples(2);
    chk(regout, 18'h00fa0);
    gain = 8'h0a;
    offset = 11'h032;
    samples(2);
    chk(regout, 18'h009c4);
    oclamp = 10'h064;
    samples(2);
    chk(regout, 18'h003e8);
    offset = 11'h000;
    oclamp = 10'h3e8;
    mode = 2'h3;
    sp_en = 1'b0;
    flags = 16'h0002;
    samples(2);
    chk(speed, 18'h00c1c);
    flags = 16'h0000;
    samples(2);
    chk(regout, 18'h3f4ac);
    chk(speed, 18'h00000);
    func = 5'h00;
    samples(2);
    chk(active, 1'b0);
    chk(speed, 18'h00064);
    func = 5'h0b;
    mode = 2'h2;
    samples(2);
    chk(active, 1'b0);
    chk(speed, 18'h00064);
    func = 5'h10;
    mode = 2'h1;
    offset = 11'h0c8;
    samples(2);
    chk(regout, 18'h003e8);
    func = 5'h0b;
    offset = 11'h000;
    sp_en = 1'b1;
    mode = 2'h0;
    kp = 12'h000;
    ti = 12'h001;
    iclamp = 10'h00a;
    samples(1);
    mode = 2'h1;
    samples(30);
    chk(regout, 18'h00064);
    ti = 12'h000;
    samples(2);
    chk(regout, 18'h00000);
    kp = 12'h064;
    mode = 2'h0;
    samples(1);
    lag = 10'h001;
    mode = 2'h1;
    samples(2);
    chk((regout > 18'sh00000 && regout < 18'sh007d0), 1'b1);
    lag = 10'h000;
    lsel = 2'h1;
    broken = 1'b1;
    samples(80);
    chk(alarm, 1'b0);
    samples(40);
    chk(alarm, 1'b1);
    chk(fault, 1'b0);
    chk(drv_en, 1'b1);
    broken = 1'b0;
    samples(2);
    chk(alarm, 1'b0);
    lsel = 2'h2;
    broken = 1'b1;
    samples(120);
    chk(fault, 1'b1);
    chk(drv_en, 1'b0);
    broken = 1'b0;
    samples(2);
    chk(fault, 1'b1);
    freset = 1'b1;
    samples(1);
    freset = 1'b0;
    chk(fault, 1'b0);
    chk(drv_en, 1'b1);
    report_and_stop();
  end
endmodule
